// ### rtl/ram_io_ports_edge_irq.sv
// Purpose: 128-byte ram, two 8-bit ports, top line edge detect and timer
// Assumes: all bus and port pins are asynchronous to clk_sys_i
// Notes: bus clock must be slow enough for two-stage sampling to settle
`timescale 1ns/1ps
module ram_io_ports_edge_irq
	import ram_io_pkg::*;
(
	input  wire logic                       clk_sys_i,
	input  wire logic                       srst_i,
	input  wire logic                       phase_two_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       select_high_i,
	input  wire logic                       select_low_n_i,
	input  wire logic                       ram_space_n_i,
	input  wire logic                       read_not_write_i,
	input  wire logic [ram_io_pkg::ADDR_W-1:0] addr_lines_i,
	input  wire logic [ram_io_pkg::DATA_W-1:0] data_lines_i,
	output logic      [ram_io_pkg::DATA_W-1:0] data_lines_o,
	output logic                            data_lines_oe_o,
	input  wire logic [7:0]                 port_a_lines_i,
	output logic      [7:0]                 port_a_lines_o,
	output logic      [7:0]                 port_a_lines_oe_o,
	input  wire logic [7:0]                 port_b_lines_i,
	output logic      [7:0]                 port_b_lines_o,
	output logic      [7:0]                 port_b_lines_oe_o,
	input  wire logic                       irq_req_n_i,
	output logic                            irq_req_n_o,
	output logic                            irq_req_n_oe_o
);
	import ram_io_pkg::*;

	localparam int BUS_W = 4 + ADDR_W + DATA_W;

	// synchroniser stages
	logic [BUS_W-1:0]  bus_s1_r;
	logic [BUS_W-1:0]  bus_s2_r;
	logic [1:0]        clk_s1_r;
	logic [1:0]        clk_s2_r;
	logic [7:0]        pa_s1_r;
	logic [7:0]        pa_s2_r;
	logic              phase_d_r;
	logic [BUS_W-1:0]  cap_r;
	logic              dev_rst;
	logic              phase_s;
	logic              bus_fall;

	// register state
	logic [7:0]        mem_r [RAM_DEPTH];
	logic [7:0]        port_a_direction_r;
	logic [7:0]        port_a_output_r;
	logic [7:0]        port_b_direction_r;
	logic [7:0]        port_b_output_r;
	logic              edge_pos_r;
	logic              edge_en_r;
	logic              edge_flag_r;
	logic              edge_lvl_r;
	logic              timer_irq_en_r;
	logic [7:0]        timer_count;
	logic              timer_flag;

	// decoded fields of the live and captured bus
	logic              l_sel;
	logic              l_rd;
	logic [ADDR_W-1:0] l_addr;
	logic              c_chip;
	logic              c_space;
	logic              c_rnw;
	logic [ADDR_W-1:0] c_addr;
	logic [DATA_W-1:0] c_data;
	logic              c_ram_wr;
	logic              c_port_wr;
	logic              c_edge_wr;
	logic              c_timer_wr;
	logic              c_timer_rd;
	logic              c_flag_rd;
	logic              edge_lvl;
	logic              edge_hit;
	logic [7:0]        rd_mux;

	// two-stage capture of the bus, phase two, reset and port A pins before any logic looks at them
	always_ff @(posedge clk_sys_i) begin
		bus_s1_r <= {select_high_i, select_low_n_i, ram_space_n_i, read_not_write_i, addr_lines_i, data_lines_i};
		bus_s2_r <= bus_s1_r;
		clk_s1_r <= {phase_two_i, reset_n_i};
		clk_s2_r <= clk_s1_r;
		pa_s1_r  <= port_a_lines_i;
		pa_s2_r  <= pa_s1_r;
	end

	assign phase_s  = clk_s2_r[1];
	assign dev_rst  = srst_i || !clk_s2_r[0];
	assign bus_fall = phase_d_r && !phase_s;

	// phase history, and a copy of the bus refreshed each clock while phase two is high
	// so the falling edge uses data that was valid before it (hold is short)
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			phase_d_r <= 1'b0;
			cap_r     <= '0;
		end else begin
			phase_d_r <= phase_s;
			if (phase_s)
				cap_r <= bus_s2_r;
		end
	end

	// live decode drives the read data while phase two is high
	assign l_sel  = bus_s2_r[BUS_W-1] && !bus_s2_r[BUS_W-2];
	assign l_rd   = l_sel && bus_s2_r[BUS_W-4] && phase_s;
	assign l_addr = bus_s2_r[DATA_W +: ADDR_W];

	// captured decode for the write and side effects at the falling edge
	assign c_chip  = cap_r[BUS_W-1] && !cap_r[BUS_W-2];
	assign c_space = cap_r[BUS_W-3];
	assign c_rnw   = cap_r[BUS_W-4];
	assign c_addr  = cap_r[DATA_W +: ADDR_W];
	assign c_data  = cap_r[DATA_W-1:0];

	assign c_ram_wr   = bus_fall && c_chip && !c_space && !c_rnw;
	assign c_port_wr  = bus_fall && c_chip && c_space && !c_addr[A_SPACE_BIT] && !c_rnw;
	assign c_edge_wr  = bus_fall && c_chip && c_space && c_addr[A_SPACE_BIT] && !c_addr[A_TWR_BIT] && !c_rnw;
	assign c_timer_wr = bus_fall && c_chip && c_space && c_addr[A_SPACE_BIT] && c_addr[A_TWR_BIT] && !c_rnw;
	assign c_timer_rd = bus_fall && c_chip && c_space && c_addr[A_SPACE_BIT] && !c_addr[A_POL_BIT] && c_rnw;
	assign c_flag_rd  = bus_fall && c_chip && c_space && c_addr[A_SPACE_BIT] && c_addr[A_POL_BIT] && c_rnw;

	// ram write at the falling edge; no reset, contents are undefined at power-up
	always_ff @(posedge clk_sys_i) begin
		if (c_ram_wr)
			mem_r[c_addr] <= c_data;
	end

	// port registers
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst) begin
			port_a_output_r    <= PORT_RST;
			port_a_direction_r <= PORT_RST;
			port_b_output_r    <= PORT_RST;
			port_b_direction_r <= PORT_RST;
		end else if (c_port_wr) begin
			unique case (c_addr[1:0])
				SEL_A_OUT: port_a_output_r    <= c_data;
				SEL_A_DIR: port_a_direction_r <= c_data;
				SEL_B_OUT: port_b_output_r    <= c_data;
				SEL_B_DIR: port_b_direction_r <= c_data;
			endcase
		end
	end

	// pin drive: enable from direction, level from output register
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst) begin
			port_a_lines_oe_o <= PORT_RST;
			port_b_lines_oe_o <= PORT_RST;
			port_a_lines_o    <= PORT_RST;
			port_b_lines_o    <= PORT_RST;
		end else begin
			port_a_lines_oe_o <= port_a_direction_r;
			port_b_lines_oe_o <= port_b_direction_r;
			port_a_lines_o    <= port_a_output_r;
			port_b_lines_o    <= port_b_output_r;
		end
	end

	// edge control: the address picks everything, data is discarded
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst) begin
			edge_pos_r <= EDGE_POS_RST;
			edge_en_r  <= EDGE_EN_RST;
		end else if (c_edge_wr) begin
			edge_pos_r <= c_addr[A_POL_BIT];
			edge_en_r  <= c_addr[A_EN_BIT];
		end
	end

	// the pin is folded with polarity so a polarity flip can look like an edge
	assign edge_lvl = pa_s2_r[7] ^ edge_pos_r;
	assign edge_hit = edge_lvl_r && !edge_lvl;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			edge_lvl_r <= 1'b0;
		else
			edge_lvl_r <= edge_lvl;
	end

	// edge flag keeps setting during device reset; an edge beats a clearing read
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			edge_flag_r <= 1'b0;
		else if (edge_hit)
			edge_flag_r <= 1'b1;
		else if (c_flag_rd)
			edge_flag_r <= 1'b0;
	end

	// timer interrupt enable follows address bit 3 on any timer access
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst)
			timer_irq_en_r <= 1'b0;
		else if (c_timer_wr || c_timer_rd)
			timer_irq_en_r <= c_addr[A_TIRQ_BIT];
	end

	interval_timer u_timer (
		.clk_sys_i  (clk_sys_i),
		.srst_i     (dev_rst),
		.tick_i     (bus_fall),
		.load_i     (c_timer_wr),
		.read_i     (c_timer_rd),
		.div_sel_i  (c_addr[1:0]),
		.load_val_i (c_data),
		.count_o    (timer_count),
		.flag_o     (timer_flag)
	);

	// open-drain request: level held low, enable asserts the pull-down
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst) begin
			irq_req_n_o    <= 1'b0;
			irq_req_n_oe_o <= 1'b0;
		end else begin
			irq_req_n_o    <= 1'b0;
			irq_req_n_oe_o <= (edge_flag_r && edge_en_r) || (timer_flag && timer_irq_en_r);
		end
	end

	// read source select from the live address
	always_comb begin
		rd_mux = 8'h00;
		if (!bus_s2_r[BUS_W-3]) begin
			rd_mux = mem_r[l_addr];
		end else if (!l_addr[A_SPACE_BIT]) begin
			unique case (l_addr[1:0])
				SEL_A_OUT: rd_mux = pa_s2_r;
				SEL_A_DIR: rd_mux = port_a_direction_r;
				SEL_B_OUT: rd_mux = port_b_output_r;
				SEL_B_DIR: rd_mux = port_b_direction_r;
			endcase
		end else if (l_addr[A_POL_BIT]) begin
			rd_mux[FLAG_TIMER] = timer_flag;
			rd_mux[FLAG_EDGE]  = edge_flag_r;
		end else begin
			rd_mux = timer_count;
		end
	end

	// data bus drive, only while phase two is high in a selected read
	always_ff @(posedge clk_sys_i) begin
		if (dev_rst) begin
			data_lines_oe_o <= 1'b0;
			data_lines_o    <= 8'h00;
		end else begin
			data_lines_oe_o <= l_rd;
			data_lines_o    <= l_rd ? rd_mux : 8'h00;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	a_reset_clears_ports: assert property (
		dev_rst |=> (port_a_direction_r == 8'h00 && port_b_direction_r == 8'h00
			&& port_a_output_r == 8'h00 && port_b_output_r == 8'h00) ##1 port_a_lines_oe_o == 8'h00)
		else $error("port registers not cleared by reset");

	a_reset_bus_off: assert property (
		dev_rst |=> !data_lines_oe_o)
		else $error("data bus driven during reset");

	a_reset_edge_mode: assert property (
		dev_rst |=> !edge_en_r && !edge_pos_r)
		else $error("edge control not reset");

	a_bus_drive_gated: assert property (
		data_lines_oe_o |-> $past(phase_s) && $past(l_sel) && $past(bus_s2_r[BUS_W-4]))
		else $error("data bus driven outside a read");

	a_hidden_write_held: assert property (
		c_port_wr && c_addr[1:0] == SEL_A_OUT && !dev_rst && port_a_direction_r == 8'h00
		|=> ##1 port_a_lines_oe_o == 8'h00 && port_a_output_r == $past(c_data, 2))
		else $error("output write on inputs misbehaved");

	a_edge_flag_sets: assert property (
		edge_hit |=> edge_flag_r)
		else $error("edge flag not set by active edge");

	a_edge_irq_gate: assert property (
		edge_flag_r && edge_en_r && !dev_rst |=> irq_req_n_oe_o && !irq_req_n_o)
		else $error("enabled edge flag did not pull request");

	a_flag_read_clears: assert property (
		c_flag_rd && !edge_hit |=> !edge_flag_r)
		else $error("flag read did not clear edge flag");

	a_edge_ctrl_addr: assert property (
		c_edge_wr && !dev_rst |=> edge_pos_r == $past(c_addr[A_POL_BIT]) && edge_en_r == $past(c_addr[A_EN_BIT]))
		else $error("edge control not taken from address");

	a_portb_read_reg: assert property (
		l_rd && bus_s2_r[BUS_W-3] && l_addr[2:0] == 3'h2 && !dev_rst |=> data_lines_o == $past(port_b_output_r))
		else $error("port b read not from output register");

	a_flag_read_zeros: assert property (
		l_rd && bus_s2_r[BUS_W-3] && l_addr[A_SPACE_BIT] && l_addr[A_POL_BIT] && !dev_rst
		|=> data_lines_o[5:0] == 6'h00 && data_lines_o[FLAG_EDGE] == $past(edge_flag_r))
		else $error("flag read layout wrong");

	a_ram_write_lands: assert property (
		c_ram_wr |=> mem_r[$past(c_addr)] == $past(c_data))
		else $error("ram write lost");

	a_porta_read_pins: assert property (
		l_rd && bus_s2_r[BUS_W-3] && l_addr[2:0] == 3'h0 && !dev_rst |=> data_lines_o == $past(pa_s2_r))
		else $error("port a read not from pin levels");

	a_dira_write: assert property (
		c_port_wr && c_addr[1:0] == SEL_A_DIR && !dev_rst |=> port_a_direction_r == $past(c_data))
		else $error("port a direction write lost");

	a_port_pin_drive: assert property (
		!dev_rst |=> port_a_lines_oe_o == $past(port_a_direction_r)
			&& port_b_lines_oe_o == $past(port_b_direction_r))
		else $error("pin enables do not follow direction");

	a_timer_irq_gate: assert property (
		timer_flag && timer_irq_en_r && !dev_rst |=> irq_req_n_oe_o)
		else $error("enabled timer flag did not pull request");

	a_irq_quiet: assert property (
		!(edge_flag_r && edge_en_r) && !(timer_flag && timer_irq_en_r) |=> !irq_req_n_oe_o)
		else $error("request pulled with no enabled source");

	a_flag_holds: assert property (
		edge_flag_r && !c_flag_rd |=> edge_flag_r)
		else $error("edge flag lost without a flag read");

	a_write_at_fall: assert property (
		c_ram_wr || c_port_wr || c_edge_wr |-> $fell(phase_s))
		else $error("write applied away from the phase two fall");

	a_irq_level_low: assert property (
		irq_req_n_oe_o |-> !irq_req_n_o)
		else $error("request driven high instead of pulled low");
endmodule : ram_io_ports_edge_irq

// ### common/ram_io_pkg.sv
// Purpose: shared constants for the ram, port and edge interrupt block
// Assumes: bus pins sampled on clk_sys_i, phase-two clock arrives as a pin
// Notes on behaviour
// - reset clears both direction and both output registers, all lines input
// - data bus drivers stay off throughout reset
// - reset disables the edge interrupt and selects falling edge
// - read_not_write high means device supplies data, low means write
// - interrupt output idles released, pulled low on an enabled edge or timer timeout
// - data lines driven only during a selected read cycle
// - direction bit 0 makes a line input, 1 makes it output
// - an output line drives its output register bit
// - port A read returns sampled pin levels
// - output register writes on input lines are kept, not driven
// - ram selected by chip select and ram_space_n low, seven address bits
// - active top line edge sets flag bit 6, interrupts only if enabled
// - edge-control write: address bit 0 polarity, bit 1 enable
// - edge-control writes ignore the data bus
// - edge flag sets regardless of direction or enable
// - changing polarity may itself set the edge flag
// - reading the flag register clears the edge flag
// - port B works like A but reads return the output register
// - timer is prescaler, 8-bit counter and interrupt logic
// - port registers at ram_space_n high, bit 2 low, bits 1:0 select
// - edge control decoded with ram_space_n high, bit 4 low, bit 2 high, write
// - flag read gives timer flag bit 7, edge flag bit 6, rest zero
package ram_io_pkg;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 7;
	localparam int          RAM_DEPTH     = 128;
	// address bit positions
	localparam int          A_POL_BIT     = 0;
	localparam int          A_EN_BIT      = 1;
	localparam int          A_SPACE_BIT   = 2;
	localparam int          A_TIRQ_BIT    = 3;
	localparam int          A_TWR_BIT     = 4;
	// port register select on address bits 1:0
	localparam logic [1:0]  SEL_A_OUT     = 2'h0;
	localparam logic [1:0]  SEL_A_DIR     = 2'h1;
	localparam logic [1:0]  SEL_B_OUT     = 2'h2;
	localparam logic [1:0]  SEL_B_DIR     = 2'h3;
	// flag register layout
	localparam int          FLAG_TIMER    = 7;
	localparam int          FLAG_EDGE     = 6;
	// reset values
	localparam logic [7:0]  PORT_RST      = 8'h00;
	localparam logic        EDGE_POS_RST  = 1'b0;
	localparam logic        EDGE_EN_RST   = 1'b0;
	// prescale shift per divide select: 1, 8, 64, 1024
	localparam int          PRESC_W       = 10;
	localparam logic [3:0]  DIV_SHIFT [4] = '{4'h0, 4'h3, 4'h6, 4'ha};
endpackage : ram_io_pkg

// ### rtl/interval_timer.sv
// Purpose: interval timer with prescaler, 8-bit down counter and timeout flag
// Assumes: tick_i pulses once per bus clock period
// Notes: after timeout the counter runs at the undivided rate
`timescale 1ns/1ps
module interval_timer
	import ram_io_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              srst_i,
	input  wire logic              tick_i,
	input  wire logic              load_i,
	input  wire logic              read_i,
	input  wire logic [1:0]        div_sel_i,
	input  wire logic [7:0]        load_val_i,
	output logic      [7:0]        count_o,
	output logic                   flag_o
);
	import ram_io_pkg::*;

	logic [PRESC_W-1:0] presc_r;
	logic [PRESC_W-1:0] presc_max_r;
	logic               step;
	logic               timeout;

	// a prescaler wrap or fast mode after timeout advances the counter
	assign step    = tick_i && (flag_o || presc_r == '0);
	assign timeout = step && count_o == 8'h00;

	// prescale divider
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			presc_r     <= '0;
			presc_max_r <= '0;
		end else if (load_i) begin
			presc_max_r <= PRESC_W'((11'h1 << DIV_SHIFT[div_sel_i]) - 11'h1);
			presc_r     <= PRESC_W'((11'h1 << DIV_SHIFT[div_sel_i]) - 11'h1);
		end else if (tick_i) begin
			presc_r <= (presc_r == '0) ? presc_max_r : presc_r - 1'b1;
		end
	end

	// counting register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			count_o <= 8'h00;
		else if (load_i)
			count_o <= load_val_i;
		else if (step)
			count_o <= count_o - 8'h01;
	end

	// timeout flag; a timeout in the same cycle as a read wins
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			flag_o <= 1'b0;
		else if (timeout)
			flag_o <= 1'b1;
		else if (load_i || read_i)
			flag_o <= 1'b0;
	end
endmodule : interval_timer

// ### test/port_peer_model.sv
// Purpose: peripheral side of both ports plus the interrupt line pull-up
// Assumes: peripheral drives every line the block leaves as an input
// Notes: ext values come from the bench; driven bits never fight the block
`timescale 1ns/1ps
module port_peer_model (
	input  wire logic [7:0] a_o_i,
	input  wire logic [7:0] a_oe_i,
	input  wire logic [7:0] ext_a_i,
	input  wire logic [7:0] b_o_i,
	input  wire logic [7:0] b_oe_i,
	input  wire logic [7:0] ext_b_i,
	input  wire logic       irq_n_i,
	input  wire logic       irq_oe_i,
	output logic      [7:0] pin_a_o,
	output logic      [7:0] pin_b_o,
	output logic            irq_pin_o
);
	// each line resolved bit by bit from the block's enable
	assign pin_a_o   = (a_o_i & a_oe_i) | (ext_a_i & ~a_oe_i);
	assign pin_b_o   = (b_o_i & b_oe_i) | (ext_b_i & ~b_oe_i);
	// external pull-up holds the line high when released
	assign irq_pin_o = irq_oe_i ? irq_n_i : 1'b1;
endmodule : port_peer_model

// ### test/ram_io_ports_edge_irq_tb_top.sv
// Purpose: self-checking bench for ram, ports and edge interrupt
// Assumes: bus cycle of 2 setup, 7 high, 8 low system clocks
// Notes: reads are queued by the driver and judged by the monitor
`timescale 1ns/1ps
module ram_io_ports_edge_irq_tb_top;
	import ram_io_pkg::*;
	localparam int MAX_CYC = 20000;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, phase = 1'b0, rst_n = 1'b1;
	logic sel_hi = 1'b0, sel_lo_n = 1'b1, rs_n = 1'b0, rnw = 1'b1;
	logic [6:0] adr = 7'h00;
	logic [7:0] dout = 8'h00, ext_a = 8'h00, ext_b = 8'h00, last_rd = 8'h00;
	logic [7:0] d_o, pa_o, pa_oe, pb_o, pb_oe, pin_a, pin_b, d, o, db, ob;
	logic d_oe, irq_o, irq_oe, irq_pin, oe_q = 1'b0;
	logic [7:0] mem_v [6];
	logic [15:0] expq [$];
	logic [15:0] e;
	int num_errors = 0, checks_done = 0, cyc = 0, seed_v;
	always #20 clk_sys_i = ~clk_sys_i;
	ram_io_ports_edge_irq dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .phase_two_i(phase),
		.reset_n_i(rst_n), .select_high_i(sel_hi), .select_low_n_i(sel_lo_n), .ram_space_n_i(rs_n),
		.read_not_write_i(rnw), .addr_lines_i(adr), .data_lines_i(dout), .data_lines_o(d_o),
		.data_lines_oe_o(d_oe), .port_a_lines_i(pin_a), .port_a_lines_o(pa_o),
		.port_a_lines_oe_o(pa_oe), .port_b_lines_i(pin_b), .port_b_lines_o(pb_o),
		.port_b_lines_oe_o(pb_oe), .irq_req_n_i(irq_pin), .irq_req_n_o(irq_o), .irq_req_n_oe_o(irq_oe));
	port_peer_model peer_u (.a_o_i(pa_o), .a_oe_i(pa_oe), .ext_a_i(ext_a), .b_o_i(pb_o),
		.b_oe_i(pb_oe), .ext_b_i(ext_b), .irq_n_i(irq_o), .irq_oe_i(irq_oe), .pin_a_o(pin_a),
		.pin_b_o(pin_b), .irq_pin_o(irq_pin));
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp_v);
		checks_done++;
		if (seen !== exp_v) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp_v, seen);
		end
	endtask : check
	task automatic clk_n(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : clk_n
	// a[7] is ram_space_n; sel is {select_high, select_low_n}, 2'b10 selects
	task automatic bus(input logic r, input logic [1:0] sel, input logic [7:0] a,
		input logic [7:0] dat, input logic [7:0] exp_v, input logic [7:0] msk);
		@(posedge clk_sys_i);
		rnw <= r;
		{sel_hi, sel_lo_n} <= sel;
		rs_n <= a[7];
		adr <= a[6:0];
		dout <= dat;
		if (r && sel == 2'b10)
			expq.push_back({msk, exp_v & msk});
		clk_n(2);
		phase <= 1'b1;
		clk_n(6);
		@(negedge clk_sys_i);
		if (!(r && sel == 2'b10))
			check("bus drive", {7'h00, d_oe}, 8'h00);
		@(posedge clk_sys_i);
		phase <= 1'b0;
		clk_n(7);
	endtask : bus
	// monitor: a read result is complete when the data drive drops
	always @(negedge clk_sys_i) begin
		if (oe_q && d_oe === 1'b0) begin
			if (expq.size() == 0)
				check("unexpected read", 8'h01, 8'h00);
			else begin
				e = expq.pop_front();
				check("read data", last_rd & e[15:8], e[7:0]);
			end
		end
		if (d_oe === 1'b1)
			last_rd = d_o;
		oe_q = (d_oe === 1'b1);
	end
	// a hang is cut short here and still reaches the verdict
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == MAX_CYC) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		seed_v = $urandom(32'he7c84d79);
		clk_n(16);
		srst_i <= 1'b0;
		clk_n(4);
		for (int i = 0; i < 4; i++)
			bus(1'b1, 2'b10, 8'(8'h80 + i), 8'h00, 8'h00, 8'hff);
		check("port a enable", pa_oe, 8'h00);
		check("port b enable", pb_oe, 8'h00);
		$display("done: reset values");
		for (int i = 0; i < 6; i++) begin
			mem_v[i] = 8'($urandom);
			bus(1'b0, 2'b10, (i == 5) ? 8'h7f : 8'(i * 25), mem_v[i], 8'h00, 8'h00);
			bus(1'b1, 2'b10, (i == 5) ? 8'h7f : 8'(i * 25), 8'h00, mem_v[i], 8'hff);
		end
		bus(1'b0, 2'b11, 8'h00, ~mem_v[0], 8'h00, 8'h00);
		bus(1'b0, 2'b00, 8'h00, ~mem_v[0], 8'h00, 8'h00);
		bus(1'b1, 2'b01, 8'h00, 8'h00, 8'h00, 8'h00);
		bus(1'b1, 2'b10, 8'h00, 8'h00, mem_v[0], 8'hff);
		$display("done: ram");
		for (int i = 0; i < 4; i++) begin
			{d, o, db, ob} = $urandom & 32'h7fffffff;
			ext_a <= 8'($urandom);
			ext_b <= 8'($urandom);
			bus(1'b0, 2'b10, 8'h80, o, 8'h00, 8'h00);
			bus(1'b0, 2'b10, 8'h81, d, 8'h00, 8'h00);
			bus(1'b0, 2'b10, 8'h82, ob, 8'h00, 8'h00);
			bus(1'b0, 2'b10, 8'h83, db, 8'h00, 8'h00);
			check("port a enable", pa_oe, d);
			check("port b enable", pb_oe, db);
			check("port a pins", pin_a, (o & d) | (ext_a & ~d));
			check("port b pins", pin_b, (ob & db) | (ext_b & ~db));
			bus(1'b1, 2'b10, 8'h80, 8'h00, pin_a, 8'hff);
			bus(1'b1, 2'b10, 8'h81, 8'h00, d, 8'hff);
			bus(1'b1, 2'b10, 8'h82, 8'h00, ob, 8'hff);
			bus(1'b1, 2'b10, 8'h83, 8'h00, db, 8'hff);
		end
		$display("done: ports");
		// top line kept an input and flag cleared before enabling
		bus(1'b0, 2'b10, 8'h81, 8'h00, 8'h00, 8'h00);
		ext_a <= 8'h80;
		bus(1'b0, 2'b10, 8'h84, 8'($urandom), 8'h00, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h00);
		ext_a <= 8'h00;
		clk_n(8);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h40, 8'h7f);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h7f);
		ext_a <= 8'h80;
		bus(1'b0, 2'b10, 8'h86, 8'($urandom), 8'h00, 8'h00);
		ext_a <= 8'h00;
		clk_n(8);
		check("irq pin", {7'h00, irq_pin}, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h40, 8'h7f);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		bus(1'b0, 2'b10, 8'h87, 8'($urandom), 8'h00, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h00);
		ext_a <= 8'h80;
		clk_n(8);
		check("irq pin", {7'h00, irq_pin}, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h40, 8'h7f);
		// rising edge made by the block itself on an output line
		bus(1'b0, 2'b10, 8'h80, 8'h00, 8'h00, 8'h00);
		bus(1'b0, 2'b10, 8'h81, 8'h80, 8'h00, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h00);
		bus(1'b0, 2'b10, 8'h80, 8'h80, 8'h00, 8'h00);
		clk_n(4);
		check("irq pin", {7'h00, irq_pin}, 8'h00);
		$display("done: edge detect");
		// device reset pin held longer than one bus period
		@(posedge clk_sys_i);
		rst_n <= 1'b0;
		clk_n(20);
		check("data drive", {7'h00, d_oe}, 8'h00);
		check("port a enable", pa_oe, 8'h00);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		rst_n <= 1'b1;
		clk_n(6);
		bus(1'b1, 2'b10, 8'h81, 8'h00, 8'h00, 8'hff);
		bus(1'b1, 2'b10, 8'h80, 8'h00, pin_a, 8'hff);
		bus(1'b1, 2'b10, 8'h82, 8'h00, 8'h00, 8'hff);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h00);
		ext_a <= 8'h00;
		clk_n(8);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h40, 8'h7f);
		$display("done: device reset");
		// timer loaded with 2 at divide by one (timeout on the third tick), its interrupt enabled
		bus(1'b0, 2'b10, 8'h9c, 8'h02, 8'h00, 8'h00);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		for (int i = 0; i < 3; i++)
			bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h00, 8'h00);
		check("irq pin", {7'h00, irq_pin}, 8'h00);
		bus(1'b1, 2'b10, 8'h85, 8'h00, 8'h80, 8'h80);
		// timer read with address bit 3 low drops the flag and the enable
		bus(1'b1, 2'b10, 8'h84, 8'h00, 8'h00, 8'h00);
		check("irq pin", {7'h00, irq_pin}, 8'h01);
		$display("done: timer");
		clk_n(4);
		check("pending reads", 8'(expq.size()), 8'h00);
		summarize();
	end
endmodule : ram_io_ports_edge_irq_tb_top
